// [rtl/voice_signal_engine.sv]
// instruction decoder and execution core of the voice signal engine
// Contract
// - one return address register; a second call overwrites it
// - bits 15..12 are the opcode, decoded per the instruction set
// - load and arithmetic use bits 12..9 as mode; bit 12 picks coefficient
// - coefficient is 12-bit two's complement spanning -1 to +1
// - mode 0000 addresses ram d5..d0; mode 0001 adds the index
// - mode 0010 selects one of eight ports by bits 2..0
// - mode 0011 signed 9-bit immediate; mode 0100 uses index value
// - 6-bit index register used as operand and address offset
// - index sub-modes: 000 write, 001 add, 100 load from accumulator
// - 30-bit accumulator is implicit source and destination
// - jumps and calls carry flag select 11..9 and target 8..0
// - program counter is 9 bits, 512 words
// - flag 000 always set, clear in processor test mode
// - flag 001 true when index is non-zero
// - flag 010 accumulator all zero; flag 011 all ones
// - flag 100 follows external frame sync
// - flags 101..111 set by flag write; 111 resets shaper and filter
// - ports 0 and 1 carry 16-bit signed samples, read and write
// - port 2 carries 12-bit signed values; port 3 reads zero
// - ports 4 to 7 are read-only 6-bit gain settings
// - load places operand in accumulator and updates pattern flags
// - store writes accumulator to ram or port; flags unchanged
// - each instruction completes in one clock cycle
// - accumulator saturates on overflow and underflow
// - untaken jump advances program counter by one
// - pc restarts at 0 when voice transmit or receive enabled
`timescale 1ns/1ps
`default_nettype none
`include "voice_signal_engine_params.svh"
module voice_signal_engine #(
  parameter int ACC_W = `VSE_ACC_W,
  parameter int PC_W  = `VSE_PC_W
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              voice_tx_enable,
  input  wire logic              voice_rx_enable,
  input  wire logic              processor_test_mode,
  input  wire logic              frame_sync,
  input  wire logic [15:0]       instr_word,
  input  wire logic [15:0]       rx_sample_in,
  input  wire logic [15:0]       tx_sample_in,
  input  wire logic [11:0]       serial_ctrl_in,
  input  wire logic [5:0]        transmit_gain_port,
  input  wire logic [5:0]        receive_gain_port,
  input  wire logic [5:0]        receive_volume_port,
  input  wire logic [5:0]        sidetone_gain_port,
  output logic [PC_W-1:0]        instr_addr,
  output logic                   running,
  output logic [15:0]            rx_sample_out,
  output logic                   rx_sample_strobe,
  output logic [15:0]            tx_sample_out,
  output logic                   tx_sample_strobe,
  output logic [11:0]            serial_ctrl_out,
  output logic                   serial_ctrl_strobe,
  output logic                   user_flag_a,
  output logic                   user_flag_b,
  output logic                   shaper_filter_reset
);
  // reset release through two flops
  logic rst_meta_q, rst_sync_q;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  wire rst_n = rst_sync_q;

  // pin inputs: three flops, change accepted when last two agree
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
      pin_q    <= 4'h0;
    end
    else
    begin
      pin_s1_q <= {voice_tx_enable, voice_rx_enable,
                   processor_test_mode, frame_sync};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end
  wire enable_any = pin_q[3] | pin_q[2];
  wire test_mode  = pin_q[1];
  wire sync_flag  = pin_q[0];

  // run control
  voice_signal_engine_pkg::run_state_t state_q, state_d;
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      voice_signal_engine_pkg::run_idle:
        if (enable_any) state_d = voice_signal_engine_pkg::run_active;
      voice_signal_engine_pkg::run_active:
        if (!enable_any) state_d = voice_signal_engine_pkg::run_idle;
      default: state_d = voice_signal_engine_pkg::run_idle;
    endcase
  end
  wire active = (state_q == voice_signal_engine_pkg::run_active);
  wire start  = (state_q == voice_signal_engine_pkg::run_idle) & enable_any;

  // architectural state
  logic [PC_W-1:0]       pc_q, pc_d, ret_q;
  logic [ACC_W-1:0]      acc_q, acc_d;
  logic [`VSE_IDX_W-1:0] idx_q, idx_d;
  logic [2:0]            uflag_q;
  logic [ACC_W-1:0]      ram [`VSE_RAM_WORDS];

  // decode
  voice_signal_engine_pkg::opcode_t opc;
  assign opc = voice_signal_engine_pkg::opcode_t'(
                 instr_word[`VSE_OPC_HI:`VSE_OPC_LO]);
  wire [2:0]      sub_mode   = instr_word[11:9];
  wire [2:0]      flag_sel   = instr_word[11:9];
  wire [PC_W-1:0] target     = instr_word[8:0];
  wire [2:0]      port_num   = instr_word[2:0];
  wire [5:0]      ram_offset = instr_word[5:0];
  wire [5:0]      ram_addr   = (sub_mode == 3'h1) ?
                               6'(ram_offset + idx_q) : ram_offset;
  wire [3:0]      group      = instr_word[15:12];
  wire            is_load    = (group[3:1] == 3'b000);
  wire            is_add     = (group[3:1] == 3'b010);
  wire            is_sub     = (group[3:1] == 3'b011);
  wire            is_mul     = (group[3:1] == 3'b100);

  // signed 16-bit sample or 12-bit value placed at the binary point
  function automatic logic [ACC_W-1:0] from_int(input logic [15:0] v);
    from_int = {v[15], v[15], v, 12'h000};
  endfunction
  function automatic logic [ACC_W-1:0] sat(input logic [ACC_W:0] v);
    if (v[ACC_W] != v[ACC_W-1])
      sat = v[ACC_W] ? ACC_W'(`VSE_ACC_MIN) : ACC_W'(`VSE_ACC_MAX);
    else
      sat = v[ACC_W-1:0];
  endfunction

  logic [ACC_W-1:0] port_word;
  always_comb
  begin
    port_word = '0;
    case (port_num)
      3'h0: port_word = from_int(rx_sample_in);
      3'h1: port_word = from_int(tx_sample_in);
      3'h2: port_word = from_int({{4{serial_ctrl_in[11]}},
                                  serial_ctrl_in});
      3'h3: port_word = '0;
      3'h4: port_word = from_int({10'h000, transmit_gain_port});
      3'h5: port_word = from_int({10'h000, receive_gain_port});
      3'h6: port_word = from_int({10'h000, receive_volume_port});
      default: port_word = from_int({10'h000, sidetone_gain_port});
    endcase
  end

  logic [ACC_W-1:0] operand;
  operand_fetch u_operand_fetch (
    .instr     (instr_word),
    .index_val (idx_q),
    .ram_word  (ram[ram_addr]),
    .port_word (port_word),
    .operand   (operand)
  );

  // arithmetic with saturation; product keeps 12 fraction bits
  wire signed [ACC_W-1:0]     acc_s  = acc_q;
  wire signed [ACC_W-1:0]     opr_s  = operand;
  wire signed [2*ACC_W-1:0]   prod   = acc_s * opr_s;
  wire signed [2*ACC_W-1:0]   prod_sh = prod >>> `VSE_FRAC_BITS;
  wire prod_ovf = (prod_sh[2*ACC_W-1:ACC_W-1] != {(ACC_W+1){1'b0}}) &&
                  (prod_sh[2*ACC_W-1:ACC_W-1] != {(ACC_W+1){1'b1}});
  wire [ACC_W-1:0] prod_val = prod_ovf ?
    (prod_sh[2*ACC_W-1] ? ACC_W'(`VSE_ACC_MIN) : ACC_W'(`VSE_ACC_MAX)) :
    prod_sh[ACC_W-1:0];
  wire [ACC_W-1:0] sum_val = sat({acc_q[ACC_W-1], acc_q} +
                                 {operand[ACC_W-1], operand});
  wire [ACC_W-1:0] dif_val = sat({acc_q[ACC_W-1], acc_q} -
                                 {operand[ACC_W-1], operand});

  // flags; equality flags follow the accumulator itself
  logic flag_val;
  always_comb
  begin
    case (flag_sel)
      3'h0: flag_val = ~test_mode;
      3'h1: flag_val = (idx_q != '0);
      3'h2: flag_val = (acc_q == '0);
      3'h3: flag_val = (acc_q == '1);
      3'h4: flag_val = sync_flag;
      3'h5: flag_val = uflag_q[0];
      3'h6: flag_val = uflag_q[1];
      default: flag_val = uflag_q[2];
    endcase
  end

  wire store_ram  = active && opc == voice_signal_engine_pkg::store_accum_op
                    && sub_mode[2:1] == 2'b00;
  wire store_port = active && opc == voice_signal_engine_pkg::store_accum_op
                    && sub_mode == 3'h2;
  wire [15:0] acc_int = acc_q[27:12];

  // one instruction per cycle
  always_comb
  begin
    pc_d  = PC_W'(pc_q + 1'b1);
    acc_d = acc_q;
    idx_d = idx_q;
    if (is_load)      acc_d = operand;
    else if (is_add)  acc_d = sum_val;
    else if (is_sub)  acc_d = dif_val;
    else if (is_mul)  acc_d = prod_val;
    case (opc)
      voice_signal_engine_pkg::subroutine_return_op: pc_d = ret_q;
      voice_signal_engine_pkg::jump_on_true_op,
      voice_signal_engine_pkg::call_on_true_op:
        if (flag_val) pc_d = target;
      voice_signal_engine_pkg::jump_on_false_op,
      voice_signal_engine_pkg::call_on_false_op:
        if (!flag_val) pc_d = target;
      voice_signal_engine_pkg::index_op:
        case (sub_mode)
          3'h0: idx_d = ram_offset;
          3'h1: idx_d = 6'(idx_q + ram_offset);
          3'h4: idx_d = acc_q[17:12];
          default: idx_d = idx_q;
        endcase
      default: ;
    endcase
  end
  wire call_taken =
    (opc == voice_signal_engine_pkg::call_on_true_op && flag_val) ||
    (opc == voice_signal_engine_pkg::call_on_false_op && !flag_val);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      state_q <= voice_signal_engine_pkg::run_idle;
      pc_q    <= `VSE_PC_RESET;
      ret_q   <= `VSE_PC_RESET;
      acc_q   <= '0;
      idx_q   <= `VSE_IDX_RESET;
      uflag_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      if (start)
        pc_q <= `VSE_PC_RESET;
      else if (active)
      begin
        pc_q  <= pc_d;
        acc_q <= acc_d;
        idx_q <= idx_d;
        if (call_taken)
          ret_q <= PC_W'(pc_q + 1'b1);
        if (opc == voice_signal_engine_pkg::flag_write_op
            && flag_sel[2] && flag_sel[1:0] != 2'b00)
          uflag_q[flag_sel[1:0] - 2'd1] <= instr_word[0];
      end
    end

  always_ff @(posedge ref_clk)
    if (store_ram)
      ram[ram_addr] <= acc_q;

  // outputs
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      rx_sample_out      <= 16'h0000;
      tx_sample_out      <= 16'h0000;
      serial_ctrl_out    <= 12'h000;
      rx_sample_strobe   <= 1'b0;
      tx_sample_strobe   <= 1'b0;
      serial_ctrl_strobe <= 1'b0;
    end
    else
    begin
      rx_sample_strobe   <= store_port && port_num == 3'h0;
      tx_sample_strobe   <= store_port && port_num == 3'h1;
      serial_ctrl_strobe <= store_port && port_num == 3'h2;
      if (store_port && port_num == 3'h0) rx_sample_out <= acc_int;
      if (store_port && port_num == 3'h1) tx_sample_out <= acc_int;
      if (store_port && port_num == 3'h2)
        serial_ctrl_out <= acc_q[23:12];
    end
  assign instr_addr          = pc_q;
  assign running             = state_q == voice_signal_engine_pkg::run_active;
  assign user_flag_a         = uflag_q[0];
  assign user_flag_b         = uflag_q[1];
  assign shaper_filter_reset = uflag_q[2];
endmodule // voice_signal_engine
`default_nettype wire

// [rtl/voice_signal_engine_params.svh]
// constants for the voice signal engine decoder
`ifndef VOICE_SIGNAL_ENGINE_PARAMS_SVH
`define VOICE_SIGNAL_ENGINE_PARAMS_SVH
`define VSE_ACC_W        30
`define VSE_PC_W         9
`define VSE_IDX_W        6
`define VSE_RAM_WORDS    64
`define VSE_OPC_HI       15
`define VSE_OPC_LO       12
`define VSE_PC_RESET     9'h000
`define VSE_IDX_RESET    6'h00
`define VSE_FRAC_BITS    12
`define VSE_ACC_MAX      30'h1FFF_FFFF
`define VSE_ACC_MIN      30'h2000_0000
`endif

// [rtl/voice_signal_engine_pkg.sv]
// types for the voice signal engine decoder
package voice_signal_engine_pkg;
  typedef enum logic [3:0] {
    load_accum_op        = 4'h0,
    load_accum_coef_op   = 4'h1,
    store_accum_op       = 4'h2,
    subroutine_return_op = 4'h3,
    add_op               = 4'h4,
    add_coef_op          = 4'h5,
    sub_op               = 4'h6,
    sub_coef_op          = 4'h7,
    accum_product_op     = 4'h8,
    accum_product_coef_op= 4'h9,
    jump_on_true_op      = 4'hA,
    jump_on_false_op     = 4'hB,
    call_on_true_op      = 4'hC,
    call_on_false_op     = 4'hD,
    flag_write_op        = 4'hE,
    index_op             = 4'hF
  } opcode_t;
  typedef enum logic [2:0] {
    mode_register = 3'h0,
    mode_indexed  = 3'h1,
    mode_port     = 3'h2,
    mode_small    = 3'h3,
    mode_index    = 3'h4
  } operand_mode_t;
  typedef enum logic [2:0] {
    always_true_flag    = 3'h0,
    index_nonnull_flag  = 3'h1,
    accum_all_low_flag  = 3'h2,
    accum_all_high_flag = 3'h3,
    frame_sync_flag     = 3'h4,
    user_a_flag         = 3'h5,
    user_b_flag         = 3'h6,
    user_c_flag         = 3'h7
  } flag_sel_t;
  typedef enum logic {
    run_idle,
    run_active
  } run_state_t;
endpackage

// [rtl/operand_fetch.sv]
// operand selection for load, add, subtract and multiply
`timescale 1ns/1ps
`default_nettype none
`include "voice_signal_engine_params.svh"
module operand_fetch (
  input  wire logic [15:0]              instr,
  input  wire logic [`VSE_IDX_W-1:0]    index_val,
  input  wire logic [`VSE_ACC_W-1:0]    ram_word,
  input  wire logic [`VSE_ACC_W-1:0]    port_word,
  output logic      [`VSE_ACC_W-1:0]    operand
);
  wire       coef_mode = instr[12];
  wire [2:0] op_mode   = instr[11:9];
  // coefficient: sign bit lands on the units bit, spans -1..+1
  wire [`VSE_ACC_W-1:0] coef_val =
    {{17{instr[11]}}, instr[11:0], 1'b0};
  wire [`VSE_ACC_W-1:0] small_val =
    {{9{instr[8]}}, instr[8:0], 12'h000};
  wire [`VSE_ACC_W-1:0] index_word =
    {12'h000, index_val, 12'h000};
  always_comb
  begin
    operand = '0;
    if (coef_mode)
      operand = coef_val;
    else
      case (op_mode)
        voice_signal_engine_pkg::mode_register: operand = ram_word;
        voice_signal_engine_pkg::mode_indexed:  operand = ram_word;
        voice_signal_engine_pkg::mode_port:     operand = port_word;
        voice_signal_engine_pkg::mode_small:    operand = small_val;
        voice_signal_engine_pkg::mode_index:    operand = index_word;
        default:                                operand = '0;
      endcase
  end
endmodule // operand_fetch
`default_nettype wire

// [testbench/voice_signal_engine_checker.sv]
// port assertions for the voice signal engine
`timescale 1ns/1ps
`default_nettype none
module voice_signal_engine_checker #(
  parameter int ACC_W = 30,
  parameter int PC_W  = 9
) (
  input wire logic            ref_clk,
  input wire logic            reset_n,
  input wire logic            running,
  input wire logic [15:0]     instr_word,
  input wire logic [PC_W-1:0] instr_addr,
  input wire logic [15:0]     rx_sample_out,
  input wire logic            rx_sample_strobe,
  input wire logic            tx_sample_strobe,
  input wire logic            user_flag_a,
  input wire logic            user_flag_b,
  input wire logic            shaper_filter_reset
);
  wire logic [3:0] opc     = instr_word[15:12];
  wire logic       jmp     = running && (opc == 4'hA || opc == 4'hB);
  wire logic       call    = running && (opc == 4'hC || opc == 4'hD);
  wire logic       ret_op  = running && opc == 4'h3;
  wire logic       seq     = running && !ret_op && !jmp && !call;
  wire logic       st_port = running && instr_word[15:9] == 7'h12;
  wire logic       st_rx   = st_port && instr_word[2:0] == 3'h0;
  wire logic       st_tx   = st_port && instr_word[2:0] == 3'h1;
  wire logic       fw_a    = running && instr_word[15:9] == 7'h75;
  wire logic       fw_c    = running && instr_word[15:9] == 7'h77;
  wire logic       fbit    = instr_word[0];
  logic            call_q;
  logic [PC_W-1:0] cpc_q;
  logic [PC_W-1:0] tgt_q;
  logic [PC_W-1:0] ret_q;
  // shadow of the single return slot, taken calls only
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      call_q <= 1'b0;
      cpc_q  <= '0;
      tgt_q  <= '0;
      ret_q  <= '0;
    end
    else
    begin
      call_q <= call;
      cpc_q  <= instr_addr;
      tgt_q  <= instr_word[PC_W-1:0];
      if (call_q && running && instr_addr == tgt_q && tgt_q != cpc_q + 1'b1)
        ret_q <= cpc_q + 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  a_pc_step: assert property (
    seq ##1 running |-> instr_addr == cpc_q + 1'b1)
    else $error("pc did not step by one");
  a_jump_dest: assert property (
    jmp ##1 running |-> instr_addr == tgt_q || instr_addr == cpc_q + 1'b1)
    else $error("jump left to a wrong address");
  a_jump_taken: assert property (
    (running && instr_word[15:9] == 7'h5E && !user_flag_b) ##1 running
    |-> instr_addr == tgt_q)
    else $error("jump on clear flag not taken");
  a_return_pc: assert property (
    ret_op ##1 running |-> instr_addr == ret_q)
    else $error("return went to a wrong address");
  a_rx_store: assert property (st_rx |=> rx_sample_strobe)
    else $error("store to port 0 gave no strobe");
  a_tx_cause: assert property (
    tx_sample_strobe |-> $past(st_tx))
    else $error("transmit strobe without a store");
  a_rx_hold: assert property (
    !rx_sample_strobe |-> $stable(rx_sample_out))
    else $error("receive sample moved without strobe");
  a_flag_a: assert property (
    fw_a |=> user_flag_a == $past(fbit))
    else $error("user flag a not written");
  a_flag_c: assert property (
    $changed(shaper_filter_reset) |-> $past(fw_c))
    else $error("shaper reset moved without write");
  a_restart_zero: assert property (
    $rose(running) |-> instr_addr == '0)
    else $error("engine did not start at zero");
  c_return: cover property (ret_op ##1 running);
  c_loop: cover property (jmp ##1 (instr_addr < cpc_q));
  c_flag_c: cover property (fw_c);
endmodule // voice_signal_engine_checker
bind voice_signal_engine voice_signal_engine_checker #(
  .ACC_W(ACC_W), .PC_W(PC_W)) u_checker (
  .ref_clk(ref_clk), .reset_n(reset_n), .running(running),
  .instr_word(instr_word), .instr_addr(instr_addr),
  .rx_sample_out(rx_sample_out), .rx_sample_strobe(rx_sample_strobe),
  .tx_sample_strobe(tx_sample_strobe), .user_flag_a(user_flag_a),
  .user_flag_b(user_flag_b), .shaper_filter_reset(shaper_filter_reset));
`default_nettype wire

// [testbench/codec_side_model.sv]
// far side: codec samples, gain settings and free-running frame sync
`timescale 1ns/1ps
`default_nettype none
module codec_side_model (
  input  wire logic        ref_clk,
  input  wire logic        load,
  input  wire logic [67:0] vals,
  output logic      [15:0] rx_sample_in,
  output logic      [15:0] tx_sample_in,
  output logic      [11:0] serial_ctrl_in,
  output logic      [5:0]  transmit_gain_port,
  output logic      [5:0]  receive_gain_port,
  output logic      [5:0]  receive_volume_port,
  output logic      [5:0]  sidetone_gain_port,
  output logic             frame_sync
);
  logic [5:0] frame_cnt_q = 6'h00;
  initial
  begin
    {sidetone_gain_port, receive_volume_port, receive_gain_port,
     transmit_gain_port, serial_ctrl_in, tx_sample_in, rx_sample_in} = '0;
    frame_sync = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    frame_cnt_q <= frame_cnt_q + 6'h01;
    frame_sync  <= frame_cnt_q < 6'h04;
    if (load)
      {sidetone_gain_port, receive_volume_port, receive_gain_port,
       transmit_gain_port, serial_ctrl_in, tx_sample_in, rx_sample_in} <= vals;
  end
endmodule // codec_side_model
`default_nettype wire

// [testbench/voice_signal_engine_bench.sv]
// self-checking bench for the voice signal engine
`timescale 1ns/1ps
`default_nettype none
module voice_signal_engine_bench;
  logic        ref_clk, reset_n, tx_en, rx_en, tmode, ld, fsync;
  logic [15:0] instr_word, rx_in, tx_in, rx_out, tx_out;
  logic [11:0] csi_in, csi_out;
  logic [5:0]  tg, rg, vol, sid;
  logic [8:0]  instr_addr;
  logic        running, rx_stb, tx_stb, csi_stb, flag_a, flag_b, shp;
  logic [95:0] vals;
  logic [17:0] q[$];
  integer      seed = 52;
  int          compares = 0;
  int          miscompares = 0;
  logic [15:0] prog [0:63] = '{
    16'h0400, 16'h2401, 16'h0402, 16'h2402, 16'h0404, 16'h4405, 16'h6403,
    16'h2400, 16'h0700, 16'h46FF, 16'h2400, 16'h2005, 16'hF003, 16'h0600,
    16'h0202, 16'h2401, 16'h0800, 16'h2401, 16'hF201, 16'h0800, 16'h2401,
    16'h0602, 16'hF800, 16'h0800, 16'h2400, 16'hF23F, 16'h0800, 16'h2400,
    16'hA219, 16'h0600, 16'hB420, 16'hA421, 16'h2401, 16'h07FF, 16'hA624,
    16'h2401, 16'hB026, 16'h2401, 16'hEA01, 16'hEE01, 16'hDC3C, 16'hEE00,
    16'h06FF, 16'h86FF, 16'h86FF, 16'h2400, 16'h0700, 16'h86FF, 16'h86FF,
    16'h2400, 16'hB832, 16'h2401, 16'h0664, 16'h9400, 16'h2400, 16'h5800,
    16'h2401, 16'hBC39, 16'h2400, 16'h3000, 16'hC03A, 16'h2401, 16'hBC29,
    16'h0000};
  voice_signal_engine u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .voice_tx_enable(tx_en),
    .voice_rx_enable(rx_en), .processor_test_mode(tmode),
    .frame_sync(fsync), .instr_word(instr_word), .rx_sample_in(rx_in),
    .tx_sample_in(tx_in), .serial_ctrl_in(csi_in),
    .transmit_gain_port(tg), .receive_gain_port(rg),
    .receive_volume_port(vol), .sidetone_gain_port(sid),
    .instr_addr(instr_addr), .running(running), .rx_sample_out(rx_out),
    .rx_sample_strobe(rx_stb), .tx_sample_out(tx_out),
    .tx_sample_strobe(tx_stb), .serial_ctrl_out(csi_out),
    .serial_ctrl_strobe(csi_stb), .user_flag_a(flag_a),
    .user_flag_b(flag_b), .shaper_filter_reset(shp));
  codec_side_model u_codec (
    .ref_clk(ref_clk), .load(ld), .vals(vals[67:0]), .rx_sample_in(rx_in),
    .tx_sample_in(tx_in), .serial_ctrl_in(csi_in),
    .transmit_gain_port(tg), .receive_gain_port(rg),
    .receive_volume_port(vol), .sidetone_gain_port(sid),
    .frame_sync(fsync));
  assign instr_word = prog[instr_addr[5:0]];
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic note(input logic [1:0] p, input logic [15:0] v);
    q.push_back({p, v});
  endtask
  // an unexpected strobe meets an unknown note and fails
  task automatic take(input logic [17:0] seen);
    logic [17:0] e;
    e = 'x;
    if (q.size() > 0)
      e = q.pop_front();
    check(seen, e);
  endtask
  task automatic stop_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic run(input logic tm);
    int          n;
    logic [15:0] r;
    logic [15:0] g;
    logic [11:0] s;
    @(posedge ref_clk);
    vals <= {$random(seed), $random(seed), $random(seed)};
    ld <= 1'b1;
    tmode <= tm;
    @(posedge ref_clk);
    ld <= 1'b0;
    r = vals[15:0];
    s = vals[43:32];
    g = 16'(vals[49:44]) + 16'(vals[55:50]);
    note(2'h1, r);
    note(2'h2, {4'h0, s});
    note(2'h0, g);
    note(2'h0, 16'hFFFF);
    note(2'h1, 16'hFFFF);
    note(2'h1, 16'h0003);
    note(2'h1, 16'h0004);
    note(2'h0, 16'h0002);
    note(2'h0, 16'h0001);
    note(2'h0, 16'h0000);
    note(2'h1, 16'hFFFF);
    if (!tm)
      note(2'h1, 16'hFFFF);
    if (!tm)
      note(2'h0, 16'hFFFF);
    note(2'h1, 16'hFFFF);
    note(2'h0, 16'hFFFF);
    note(2'h0, 16'h0000);
    note(2'h1, 16'h0000);
    note(2'h0, 16'h0032);
    note(2'h1, 16'h0031);
    tx_en <= !tm;
    rx_en <= tm;
    n = 0;
    while ((q.size() > 0 || instr_addr !== 9'h039) && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (4) @(posedge ref_clk);
    check({15'h0000, flag_a, flag_b, shp}, 18'h0_0004);
    check({9'h000, instr_addr}, 18'h0_0039);
    check(18'(q.size()), 18'h0_0000);
    tx_en <= 1'b0;
    rx_en <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    if (rx_stb)
      take({2'h0, rx_out});
    if (tx_stb)
      take({2'h1, tx_out});
    if (csi_stb)
      take({2'h2, 4'h0, csi_out});
  end
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    stop_test;
  end
  initial
  begin
    reset_n = 1'b0;
    {tx_en, rx_en, tmode, ld} = 4'h0;
    vals = '0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run(1'b0);
    run(1'b1);
    stop_test;
  end
endmodule // voice_signal_engine_bench
`default_nettype wire
